// >>> src/rtc_core.v
// BCD real time clock with alarm RAM, comparator and two interrupts
`timescale 1ns/1ps
`include "rtc_consts.vh"
module rtc_core #(
    parameter XTAL_DIV = `CLK_HZ / `XTAL_HZ
) (
    // Clock and reset
    input  wire       clk,
    input  wire       rst,
    // Microprocessor bus, active-low strobes from pins
    input  wire [4:0] addr,
    input  wire [7:0] data_in,
    input  wire       cs_n,
    input  wire       rd_n,
    input  wire       wr_n,
    input  wire       power_up,
    output reg  [7:0] data_out,
    output reg        data_oe,
    // Interrupts
    output reg        irq,
    output reg        irq_oe,
    output reg        alarm_irq_n_out,
    output reg        alarm_irq_n_oe
);
    localparam TICK_DIV  = `CLK_HZ / `TICK_HZ;
    localparam ROLL_CYC  = (`ROLL_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam XTAL_TICKS = `XTAL_HZ / `TICK_HZ;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: two flops before any logic
    reg [16:0] s1_reg;
    reg [16:0] s2_reg;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_reg <= 17'h1c000;
            s2_reg <= 17'h1c000;
        end else begin
            s1_reg <= {cs_n, rd_n, wr_n, power_up, addr, data_in};
            s2_reg <= s1_reg;
        end
    end
    wire       cs_s  = ~s2_reg[16];
    wire       rd_s  = ~s2_reg[15];
    wire       wr_s  = ~s2_reg[14];
    wire       pu_s  = s2_reg[13];
    wire [4:0] a_s   = s2_reg[12:8];
    wire [7:0] d_s   = s2_reg[7:0];

    // Bus ignored while powered down
    wire rd_act = cs_s & rd_s & pu_s; // R18
    wire wr_act = cs_s & wr_s & pu_s; // R18
    reg  rd_d_reg;
    reg  wr_d_reg;
    reg  [4:0] ra_reg;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_d_reg <= 1'b0;
            wr_d_reg <= 1'b0;
            ra_reg   <= 5'h00;
        end else begin
            rd_d_reg <= rd_act;
            wr_d_reg <= wr_act;
            if (rd_act)
                ra_reg <= a_s;
        end
    end
    wire rd_start = rd_act & ~rd_d_reg;
    wire rd_end   = ~rd_act & rd_d_reg;    // trailing edge of a read
    wire wr_start = wr_act & ~wr_d_reg;

    ////////////////////////////////////////////////////////////////////////
    // Time base: 1 kHz tick divided from the 25 MHz clk, into the thousandths digit
    reg [15:0] xdiv_reg;
    reg [15:0] tdiv_reg;
    reg        tick_reg;
    reg [15:0] roll_reg;
    reg [7:0]  cnt0_reg, cnt1_reg, cnt2_reg, cnt3_reg;
    reg [7:0]  cnt4_reg, cnt5_reg, cnt6_reg, cnt7_reg;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            xdiv_reg <= 16'h0000;
            tdiv_reg <= 16'h0000;
            tick_reg <= 1'b0;
            roll_reg <= 16'h0000;
        end else begin
            tick_reg <= 1'b0;
            // Crystal edge approximated from clk, drives nothing; the tick comes every TICK_DIV clk cycles
            if (xdiv_reg == XTAL_DIV[15:0] - 16'h0001)
                xdiv_reg <= 16'h0000; // R5
            else
                xdiv_reg <= xdiv_reg + 16'h0001;
            if (tdiv_reg == TICK_DIV[15:0] - 16'h0001) begin
                tdiv_reg <= 16'h0000;
                tick_reg <= 1'b1;
            end else begin
                tdiv_reg <= tdiv_reg + 16'h0001;
            end
            // Window opens on every 1 kHz step; a counter read inside it may tear
            if (tick_reg)
                roll_reg <= ROLL_CYC[15:0];
            else if (roll_reg != 16'h0000)
                roll_reg <= roll_reg - 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counter digits; each byte holds two BCD digits, unused bits stay zero
    reg       go_step;

    // BCD byte increment with wrap to lo at hi
    function [7:0] bcd_inc;
        input [7:0] v;
        input [7:0] hi;
        input [7:0] lo;
        begin
            if (v == hi)
                bcd_inc = lo;
            else if (v[3:0] == 4'h9)
                bcd_inc = {v[7:4] + 4'h1, 4'h0};
            else
                bcd_inc = {v[7:4], v[3:0] + 4'h1};
        end
    endfunction

    // Month length, no leap-year correction
    wire [7:0] mday_max = (cnt7_reg == 8'h02) ? 8'h28 :
                          (cnt7_reg == 8'h04 || cnt7_reg == 8'h06 ||
                           cnt7_reg == 8'h09 || cnt7_reg == 8'h11) ? 8'h30 : 8'h31; // R4

    // Ripple carries
    wire c0 = tick_reg & (cnt0_reg[7:4] == 4'h9);    // R3
    wire c1 = c0 & (cnt1_reg == 8'h99);
    wire c2 = c1 & (cnt2_reg == 8'h59);
    wire c3 = (c2 | go_step) & (cnt3_reg == 8'h59);
    wire c4 = c3 & (cnt4_reg == 8'h23);               // R4
    wire c6 = c4 & (cnt6_reg == mday_max);
    wire c7 = c6 & (cnt7_reg == 8'h12);
    wire wk = c4 & (cnt5_reg == 8'h07);

    wire cnt_wr  = wr_start & (a_s <= `ADDR_CNT_LAST);
    wire cnt_clr = wr_start & (a_s == `ADDR_CNT_RESET) & (d_s == `RESET_CODE); // R22
    wire go_cmd  = wr_start & (a_s == `ADDR_GO);                               // R21

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            {cnt0_reg, cnt1_reg, cnt2_reg, cnt3_reg} <= 32'h0000_0000;
            {cnt4_reg, cnt5_reg, cnt6_reg, cnt7_reg} <= 32'h0001_0101;
            go_step <= 1'b0;
        end else begin
            go_step <= 1'b0;
            if (cnt_clr) begin
                {cnt0_reg, cnt1_reg, cnt2_reg, cnt3_reg} <= 32'h0000_0000;
                {cnt4_reg, cnt5_reg, cnt6_reg, cnt7_reg} <= 32'h0001_0101;
            end else if (go_cmd) begin
                cnt0_reg <= 8'h00; // R21
                cnt1_reg <= 8'h00;
                cnt2_reg <= 8'h00;
                go_step  <= (cnt2_reg > `GO_SEC_LIMIT); // R21
            end else if (cnt_wr) begin
                // Masks drop unused bits
                case (a_s[2:0])
                    3'd0: cnt0_reg <= d_s & 8'hf0; // R2
                    3'd1: cnt1_reg <= d_s;
                    3'd2: cnt2_reg <= d_s & 8'h7f;
                    3'd3: cnt3_reg <= d_s & 8'h7f;
                    3'd4: cnt4_reg <= d_s & 8'h3f;
                    3'd5: cnt5_reg <= d_s & 8'h07;
                    3'd6: cnt6_reg <= d_s & 8'h3f;
                    default: cnt7_reg <= d_s & 8'h1f;
                endcase
            end else begin
                if (tick_reg)
                    cnt0_reg <= {((cnt0_reg[7:4] == 4'h9) ? 4'h0 : cnt0_reg[7:4] + 4'h1), 4'h0};
                if (c0) cnt1_reg <= bcd_inc(cnt1_reg, 8'h99, 8'h00);
                if (c1) cnt2_reg <= bcd_inc(cnt2_reg, 8'h59, 8'h00);
            end
            if (!cnt_clr && !cnt_wr) begin
                if (c2 | go_step) cnt3_reg <= bcd_inc(cnt3_reg, 8'h59, 8'h00);
                if (c3) cnt4_reg <= bcd_inc(cnt4_reg, 8'h23, 8'h00);
                if (c4) cnt5_reg <= bcd_inc(cnt5_reg, 8'h07, 8'h01);
                if (c4) cnt6_reg <= bcd_inc(cnt6_reg, mday_max, 8'h01);
                if (c6) cnt7_reg <= bcd_inc(cnt7_reg, 8'h12, 8'h01);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // RAM, 16 digits of 4 bits, 14 of them compared
    wire [63:0] ram_flat;
    wire [7:0]  ram_rd;
    wire        ram_wr  = wr_start & (a_s >= `ADDR_RAM_FIRST) & (a_s <= `ADDR_RAM_LAST); // R19
    wire        ram_clr = wr_start & (a_s == `ADDR_RAM_RESET) & (d_s == `RESET_CODE);    // R22

    alarm_ram u_ram (
        .clk       (clk),
        .rst       (rst),
        .wr_en     (ram_wr),
        .wr_addr   (a_s[2:0]),
        .wr_data   (d_s),         // R6
        .clear_all (ram_clr),
        .rd_addr   (a_s[2:0]),
        .rd_data   (ram_rd),
        .flat      (ram_flat)
    );

    ////////////////////////////////////////////////////////////////////////
    // Digit comparator; RAM digits with 3 in top bits are wildcards
    wire [63:0] cnt_flat = {cnt7_reg, cnt6_reg, cnt5_reg, cnt4_reg,
                            cnt3_reg, cnt2_reg, cnt1_reg, cnt0_reg};
    reg  [15:0] dig_ok;
    integer k;
    always @* begin
        for (k = 0; k < 16; k = k + 1)
            dig_ok[k] = (ram_flat[k*4+3 -: 2] == 2'b11) |              // R8
                        (ram_flat[k*4 +: 4] == cnt_flat[k*4 +: 4]);    // R9
        dig_ok[0]  = 1'b1;  // R7
        dig_ok[11] = 1'b1;  // R7
    end
    wire match_now = &dig_ok;
    reg  match_reg;
    reg  match_d_reg;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            match_reg   <= 1'b0;
            match_d_reg <= 1'b0;
        end else begin
            // Sampled once the ripple has settled
            if (roll_reg == 16'h0001)
                match_reg <= match_now;
            match_d_reg <= match_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Periodic interrupt sources, one bit each in control and status
    wire [7:0] src;
    assign src[`IRQ_10HZ]  = c0 & (cnt1_reg[3:0] == 4'h9);
    assign src[`IRQ_1HZ]   = c1;
    assign src[`IRQ_MIN]   = c2;
    assign src[`IRQ_HOUR]  = c3;
    assign src[`IRQ_DAY]   = c4;
    assign src[`IRQ_WEEK]  = wk;
    assign src[`IRQ_MONTH] = c7;
    assign src[`IRQ_MATCH] = match_reg & ~match_d_reg; // R10

    reg [7:0] ictl_reg;
    reg [7:0] ista_reg;
    reg       alarm_en_reg;
    reg       roll_flag_reg;
    wire      ista_clr = rd_end & (ra_reg == `ADDR_IRQ_STATUS);   // R14
    wire      roll_clr = rd_end & (ra_reg == `ADDR_ROLL_STATUS);  // R20

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ictl_reg      <= 8'h00;
            ista_reg      <= 8'h00;
            alarm_en_reg  <= 1'b0;
            roll_flag_reg <= 1'b0;
        end else begin
            if (wr_start && a_s == `ADDR_IRQ_CTRL)
                ictl_reg <= d_s; // R11
            if (wr_start && a_s == `ADDR_ALARM_EN)
                alarm_en_reg <= d_s[0]; // R16
            // Set wins over the clear in the same cycle
            ista_reg <= (ista_clr ? 8'h00 : ista_reg) | (src & ictl_reg); // R12 R23 R24
            roll_flag_reg <= (roll_clr ? 1'b0 : roll_flag_reg) |
                             (rd_start & (a_s <= `ADDR_CNT_LAST) & (roll_reg != 16'h0000)); // R20
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux and registered outputs
    reg [7:0] rd_mux;
    always @* begin
        rd_mux = 8'h00;
        if (a_s <= `ADDR_CNT_LAST)
            rd_mux = cnt_flat[a_s[2:0]*8 +: 8]; // R1
        else if (a_s <= `ADDR_RAM_LAST)
            rd_mux = ram_rd;
        else if (a_s == `ADDR_IRQ_STATUS)
            rd_mux = ista_reg; // R13
        else if (a_s == `ADDR_IRQ_CTRL)
            rd_mux = ictl_reg;
        else if (a_s == `ADDR_ROLL_STATUS)
            rd_mux = {7'h00, roll_flag_reg}; // R20
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            data_out        <= 8'h00;
            data_oe         <= 1'b0;
            irq             <= 1'b0;
            irq_oe          <= 1'b0;
            alarm_irq_n_out <= 1'b0;
            alarm_irq_n_oe  <= 1'b0;
        end else begin
            data_out        <= rd_mux;
            data_oe         <= rd_act; // R18
            irq             <= (ista_reg != 8'h00); // R12 R14
            irq_oe          <= pu_s; // R18
            alarm_irq_n_out <= 1'b0;
            alarm_irq_n_oe  <= alarm_en_reg & match_reg; // R15 R17
        end
    end
endmodule

// >>> src/rtc_consts.vh
// Constants for the BCD real time clock core with alarm RAM
// How it works
// R1 - Time counter is 4-bit BCD digits, two digits per byte access.
// R2 - Unused counter digit bits read zero and are ignored on write.
// R3 - Counter chain runs from ten-thousandths of seconds up to months, rippling; here the ten-thousandths digit stays zero and the tick enters at thousandths.
// R4 - Hours count 0-23; calendar has no leap-year month correction.
// R5 - All timekeeping derives from a 32,768 Hz time base; here the 1 kHz tick is divided from the 25 MHz clk instead.
// R6 - 56 RAM bits as 14 four-bit digits, every bit writable.
// R7 - Compare RAM to counter per digit, skipping two unused digits.
// R8 - RAM digit with top two bits set always matches.
// R9 - Unused counter bits match only when the RAM bits are zero.
// R10 - Periodic interrupt selectable among 10 Hz, 1 Hz, minute..month, and match; the month bit here fires only on the month 12 to 01 wrap.
// R11 - Host enables sources by writing ones into the control register.
// R12 - Enabled source rollover latches into status and raises interrupt output.
// R13 - Status read shows a one for each source that interrupted.
// R14 - End of status read strobe clears the interrupt and its output.
// R15 - Standby interrupt is active-low open drain: enabled and matching.
// R16 - Write to standby location sets enable from data_bit0.
// R17 - Standby interrupt follows match level, asserts at once if matching.
// R18 - Power-down low ignores the bus and floats outputs except standby.
// R19 - Address map: counters 00-07, RAM 08-0F, control at 10-16, test 1F; here 1F has no function and reads zero.
// R20 - Counter read during rollover pulse sets flag, read at 14, cleared after.
// R21 - Write at 15 clears sub-minute counters; minutes step if seconds above 40.
// R22 - All ones at 12 resets counters, all ones at 13 resets RAM.
// R23 - Status bits use the same positions as control bits.
// R24 - After status clear, output stays low until next enabled rollover.
`ifndef RTC_CONSTS_VH
`define RTC_CONSTS_VH

// Register addresses (5-bit)
`define ADDR_CNT_LAST    5'h07
`define ADDR_RAM_FIRST   5'h08
`define ADDR_RAM_LAST    5'h0f
`define ADDR_IRQ_STATUS  5'h10
`define ADDR_IRQ_CTRL    5'h11
`define ADDR_CNT_RESET   5'h12
`define ADDR_RAM_RESET   5'h13
`define ADDR_ROLL_STATUS 5'h14
`define ADDR_GO          5'h15
`define ADDR_ALARM_EN    5'h16
`define ADDR_TEST        5'h1f

// Reset code written to the reset locations
`define RESET_CODE       8'hff

// Interrupt source bit positions
`define IRQ_10HZ   0
`define IRQ_1HZ    1
`define IRQ_MIN    2
`define IRQ_HOUR   3
`define IRQ_DAY    4
`define IRQ_WEEK   5
`define IRQ_MONTH  6
`define IRQ_MATCH  7

// Timing
`define CLK_HZ       25000000
`define XTAL_HZ      32768
`define TICK_HZ      1000
`define ROLL_PULSE_NS 61000
`define CLK_PERIOD_NS 40

// Seconds threshold for minute step on the start command
`define GO_SEC_LIMIT 8'h40

`endif

// >>> src/alarm_ram.v
// Alarm and storage RAM: 8 bytes, 14 digits used, registered read
`timescale 1ns/1ps
module alarm_ram (
    // Clock and reset
    input  wire        clk,
    input  wire        rst,
    // Write port
    input  wire        wr_en,
    input  wire [2:0]  wr_addr,
    input  wire [7:0]  wr_data,
    input  wire        clear_all,
    // Registered read port
    input  wire [2:0]  rd_addr,
    output reg  [7:0]  rd_data,
    // Whole contents for the comparator
    output wire [63:0] flat
);
    reg [7:0] mem [0:7];
    integer i;

    // Storage, every bit writable; clear_all zeroes the lot
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            for (i = 0; i < 8; i = i + 1)
                mem[i] <= 8'h00;
            rd_data <= 8'h00;
        end else begin
            if (clear_all) begin
                for (i = 0; i < 8; i = i + 1)
                    mem[i] <= 8'h00;
            end else if (wr_en) begin
                mem[wr_addr] <= wr_data;
            end
            rd_data <= mem[rd_addr];
        end
    end

    assign flat = {mem[7], mem[6], mem[5], mem[4], mem[3], mem[2], mem[1], mem[0]};
endmodule

// >>> testbench/rtc_core_properties.sv
// Concurrent checks on the clock core pins
`timescale 1ns/1ps
module rtc_core_properties (
    // Clock, reset, bus pins and outputs
    input wire       clk,
    input wire       rst,
    input wire [4:0] addr,
    input wire [7:0] data_in,
    input wire       cs_n,
    input wire       rd_n,
    input wire       wr_n,
    input wire       power_up,
    input wire       data_oe,
    input wire       irq,
    input wire       irq_oe,
    input wire       alarm_irq_n_out,
    input wire       alarm_irq_n_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    reg  [3:0] since_rd_reg;
    wire       rd_act = !cs_n && !rd_n;
    ////////////////////////////////////////
    // Age of last read strobe; saturates so it never wraps
    always @(posedge clk or posedge rst) begin
        if (rst)
            since_rd_reg <= 4'hf;
        else
            since_rd_reg <= rd_act ? 4'h0 : since_rd_reg + {3'h0, since_rd_reg != 4'hf};
    end
    // Status read held, then released long enough to clear
    sequence status_read_s;
        (rd_act && power_up && addr == 5'h10) [*4] ##1 rd_n [*6];
    endsequence
    // Zero on data_bit0 written to the standby enable
    sequence alarm_off_s;
        (!cs_n && !wr_n && power_up && addr == 5'h16 && !data_in[0]) [*3];
    endsequence
    chk_pd_float: assert property (!power_up [*5] |-> !data_oe && !irq_oe)
        else $error("outputs driven in power down");
    chk_irq_driven: assert property (power_up [*5] |-> irq_oe)
        else $error("irq floated while powered");
    chk_read_answer: assert property ((rd_act && power_up) [*5] |-> data_oe)
        else $error("read not answered");
    chk_read_release: assert property ((cs_n || rd_n) [*5] |-> !data_oe)
        else $error("data bus held after read");
    chk_irq_clear_src: assert property ($fell(irq) |-> since_rd_reg < 4'h8)
        else $error("irq dropped without a read");
    chk_status_clear: assert property (status_read_s |-> !irq)
        else $error("irq high after status read");
    chk_alarm_drain: assert property (alarm_irq_n_out == 1'b0)
        else $error("standby pin driven high");
    chk_alarm_disable: assert property (alarm_off_s |-> ##[1:4] !alarm_irq_n_oe)
        else $error("standby irq not disabled");
endmodule
bind rtc_core rtc_core_properties u_props (
    .clk(clk), .rst(rst), .addr(addr), .data_in(data_in), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .power_up(power_up), .data_oe(data_oe), .irq(irq), .irq_oe(irq_oe),
    .alarm_irq_n_out(alarm_irq_n_out), .alarm_irq_n_oe(alarm_irq_n_oe));

// >>> testbench/rtc_host_model.sv
// Host bus model driving the core pins
`timescale 1ns/1ps
module rtc_host_model (
    // Clock
    input  wire       clk,
    // Pins towards the core, idle and powered at time zero
    output reg  [4:0] addr     = 5'h00,
    output reg  [7:0] data_in  = 8'h00,
    output reg        cs_n     = 1'b1,
    output reg        rd_n     = 1'b1,
    output reg        wr_n     = 1'b1,
    output reg        power_up = 1'b1,
    // Read answer
    input  wire [7:0] data_out,
    input  wire       data_oe
);
    reg [7:0] q;
    reg       q_oe;
    ////////////////////////////////////////
    // Strobes held seven cycles, past the four-cycle answer
    task access(input [4:0] a, input [7:0] d, input is_wr);
        begin
            @(posedge clk);
            #2;
            addr = a;
            data_in = d;
            cs_n = 1'b0;
            wr_n = !is_wr;
            rd_n = is_wr;
            repeat (7) @(posedge clk);
            q = data_out;
            q_oe = data_oe;
            #2;
            cs_n = 1'b1;
            wr_n = 1'b1;
            rd_n = 1'b1;
            // Released bus must not look like the last byte
            data_in = ~d;
            repeat (5) @(posedge clk);
        end
    endtask
    // Power-down pin, moved just after an edge
    task pwr(input v);
        begin
            @(posedge clk);
            #2;
            power_up = v;
        end
    endtask
endmodule

// >>> testbench/rtc_core_tb_top.sv
// Self-checking bench for the BCD clock core
`timescale 1ns/1ps
module rtc_core_tb_top;
    reg        clk;
    reg        rst;
    wire [4:0] addr;
    wire [7:0] data_in;
    wire [7:0] data_out;
    wire       cs_n, rd_n, wr_n, power_up, data_oe;
    wire       irq, irq_oe, alarm_irq_n_out, alarm_irq_n_oe;
    integer    failures;
    integer    comparisons;
    integer    i;
    integer    p;
    ////////////////////////////////////////
    rtc_host_model host (.clk(clk), .addr(addr), .data_in(data_in), .cs_n(cs_n),
        .rd_n(rd_n), .wr_n(wr_n), .power_up(power_up), .data_out(data_out),
        .data_oe(data_oe));
    rtc_core dut (.clk(clk), .rst(rst), .addr(addr), .data_in(data_in), .cs_n(cs_n),
        .rd_n(rd_n), .wr_n(wr_n), .power_up(power_up), .data_out(data_out),
        .data_oe(data_oe), .irq(irq), .irq_oe(irq_oe),
        .alarm_irq_n_out(alarm_irq_n_out), .alarm_irq_n_oe(alarm_irq_n_oe));
    // 25 MHz system clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Count a comparison, report a mismatch at once
    task chk(input string name, input [7:0] exp, input [7:0] got);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    task wr(input [4:0] a, input [7:0] d);
        host.access(a, d, 1'b1);
    endtask
    task rd(input [4:0] a, input [7:0] exp);
        begin
            host.access(a, 8'h00, 1'b0);
            chk("read enable", 8'h01, {7'h00, host.q_oe});
            chk($sformatf("addr %h", a), exp, host.q);
        end
    endtask
    // Bounded wait for irq (sel 0) or standby irq (sel 1)
    task wait_lvl(input sel, input val, input integer n);
        integer k;
        begin
            for (k = 0; k < n && (sel ? alarm_irq_n_oe : irq) !== val; k = k + 1)
                @(posedge clk);
            #2;
        end
    endtask
    // Complementary patterns; every RAM bit sees both levels
    function [7:0] ram_val(input integer a, input integer q);
        ram_val = (q != 0 ? 8'ha5 : 8'h5a) ^ {2{a[3:0]}};
    endfunction
    ////////////////////////////////////////
    // Reset state, unmapped place, unused bits, start command
    task t_regs;
        begin
            rd(5'h11, 8'h00);
            rd(5'h1e, 8'h00);
            wr(5'h04, 8'h23);
            rd(5'h04, 8'h23);
            wr(5'h05, 8'hf5);
            rd(5'h05, 8'h05);
            wr(5'h07, 8'hf2);
            rd(5'h07, 8'h12);
            wr(5'h12, 8'hff);
            rd(5'h04, 8'h00);
            wr(5'h02, 8'h45);
            wr(5'h15, 8'ha5);
            rd(5'h02, 8'h00);
            rd(5'h03, 8'h01);
            wr(5'h02, 8'h30);
            wr(5'h15, 8'h00);
            rd(5'h03, 8'h01);
        end
    endtask
    // Both levels in every RAM bit, then the RAM reset code
    task t_ram;
        begin
            for (p = 0; p < 2; p = p + 1) begin
                for (i = 8; i < 16; i = i + 1)
                    wr(i[4:0], ram_val(i, p));
                for (i = 8; i < 16; i = i + 1)
                    rd(i[4:0], ram_val(i, p));
            end
            wr(5'h13, 8'hff);
            for (i = 8; i < 16; i = i + 1)
                rd(i[4:0], 8'h00);
        end
    endtask
    // Every digit one step short of its wrap, so one tick rolls all seven sources
    task t_periodic;
        begin
            wr(5'h11, 8'h7f);
            wr(5'h00, 8'h90);
            wr(5'h01, 8'h99);
            wr(5'h02, 8'h59);
            wr(5'h03, 8'h59);
            wr(5'h04, 8'h23);
            wr(5'h05, 8'h07);
            wr(5'h06, 8'h31);
            wr(5'h07, 8'h12);
            wait_lvl(1'b0, 1'b1, 40000);
            chk("irq", 8'h01, {7'h00, irq});
            rd(5'h02, 8'h00);
            rd(5'h07, 8'h01);
            rd(5'h10, 8'h7f);
            chk("irq", 8'h00, {7'h00, irq});
            rd(5'h14, 8'h01);
            rd(5'h14, 8'h00);
            rd(5'h10, 8'h00);
        end
    endtask
    // Comparator, standby irq and power down
    task t_alarm;
        begin
            for (i = 8; i < 16; i = i + 1)
                wr(i[4:0], i == 10 ? 8'h8f : i == 8 ? 8'hf5 : i == 13 ? 8'h5f : 8'hff);
            wr(5'h11, 8'h80);
            wr(5'h16, 8'h01);
            repeat (6000) @(posedge clk);
            chk("alarm", 8'h00, {7'h00, alarm_irq_n_oe});
            wr(5'h0a, 8'hff);
            // Match is latched once per millisecond, so wait past one tick
            wait_lvl(1'b1, 1'b1, 30000);
            chk("alarm", 8'h01, {7'h00, alarm_irq_n_oe});
            wait_lvl(1'b0, 1'b1, 100);
            rd(5'h10, 8'h80);
            host.pwr(1'b0);
            wr(5'h16, 8'h00);
            chk("irq drive", 8'h00, {7'h00, irq_oe});
            chk("alarm", 8'h01, {7'h00, alarm_irq_n_oe});
            host.pwr(1'b1);
            repeat (8) @(posedge clk);
            wr(5'h16, 8'hfe);
            chk("alarm", 8'h00, {7'h00, alarm_irq_n_oe});
            wr(5'h16, 8'h01);
            chk("alarm", 8'h01, {7'h00, alarm_irq_n_oe});
            wr(5'h13, 8'hff);
            wait_lvl(1'b1, 1'b0, 30000);
            chk("alarm", 8'h00, {7'h00, alarm_irq_n_oe});
        end
    endtask
    task print_verdict;
        begin
            $display("comparisons %0d failures %0d", comparisons, failures);
            if (failures == 0 && comparisons > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    // Reset for 12 cycles, then the scenarios
    initial begin
        failures = 0;
        comparisons = 0;
        rst = 1'b1;
        repeat (12) @(posedge clk);
        #2;
        rst = 1'b0;
        repeat (3) @(posedge clk);
        t_regs;
        t_ram;
        t_periodic;
        t_alarm;
        print_verdict;
    end
    // Watchdog; the scenarios need under 85000 cycles
    initial begin
        repeat (95000) @(posedge clk);
        failures = failures + 1;
        print_verdict;
    end
endmodule
